/* spf_pkg.sv */
// Constants shared by the serial port block: register map, fields, modes.
// Assumes a 32-bit APB with byte addresses; registers sit in the low 16 bits.
package spf_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_STAT = 12'h000;
   localparam logic [11:0] OFF_CON1 = 12'h004;
   localparam logic [11:0] OFF_CON2 = 12'h008;
   localparam logic [11:0] OFF_DATA = 12'h00c;
   // Status/control fields
   localparam int B_PORT_ON   = 15;
   localparam int B_IDLE_HALT = 13;
   localparam int B_CNT_LO    = 8;
   localparam int B_SH_EMPTY  = 7;
   localparam int B_OVF       = 6;
   localparam int B_RX_EMPTY  = 5;
   localparam int B_IRQ_CONDITION_SEL_LO  = 2;
   localparam int B_TX_FULL   = 1;
   localparam int B_RX_FULL   = 0;
   // Control one fields
   localparam int B_CLK_OFF   = 12;
   localparam int B_DOUT_OFF  = 11;
   localparam int B_WIDE      = 10;
   localparam int B_SMP       = 9;
   localparam int B_CKE       = 8;
   localparam int B_SELECT_PIN_USE      = 7;
   localparam int B_CKP       = 6;
   localparam int B_MASTER    = 5;
   localparam int B_SEC_LO    = 2;
   localparam int B_PRI_LO    = 0;
   // Control two fields
   localparam int B_FRAMED    = 15;
   localparam int B_SYNC_DIR  = 14;
   localparam int B_SYNC_POL  = 13;
   localparam int B_SYNC_EDGE = 1;
   localparam int B_FIFO_ON   = 0;
   // Writable bits, everything else reads as zero
   localparam logic [15:0] CON1_WMASK = 16'h1fff;
   localparam logic [15:0] CON2_WMASK = 16'he003;
   localparam logic [15:0] RESET_VAL  = 16'h0000;
   // Transfer sizes in bits
   localparam logic [5:0] BITS_BYTE = 6'h08;
   localparam logic [5:0] BITS_WORD = 6'h10;
   // Primary prescale ratios and secondary base
   localparam logic [6:0] PRI_1  = 7'h01;
   localparam logic [6:0] PRI_4  = 7'h04;
   localparam logic [6:0] PRI_16 = 7'h10;
   localparam logic [6:0] PRI_64 = 7'h40;
   localparam logic [3:0] SEC_BASE = 4'h8;
   localparam int FIFO_DEPTH_DEF = 8;

   typedef enum logic [2:0] {
      SEL_RX_EMPTIED = 3'h0,
      SEL_RX_AVAIL   = 3'h1,
      SEL_RX_3Q      = 3'h2,
      SEL_RX_FULL    = 3'h3,
      SEL_TX_SLOT    = 3'h4,
      SEL_TX_DONE    = 3'h5,
      SEL_TX_DRAINED = 3'h6,
      SEL_TX_FULL    = 3'h7
   } spf_irq_condition_sel_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_PRE   = 2'h1,
      ST_SHIFT = 2'h2,
      ST_ARM   = 2'h3
   } spf_state_e;
endpackage

/* spf_port.sv */
// Serial peripheral port: master/slave shifter, prescaler, framing, FIFOs.
// Assumes an APB master on pclk; pins come from outside and are synchronised.
//
// Overview of operation
// - Port enable hands pins to the port
// - Idle-halt bit stops port during idle mode
// - Element count: pending (master) or unread (slave)
// - Flags for empty shifter and empty receive FIFO
// - Unread data: drop new word, set overflow
// - Select codes 111-100 pick transmit-side events
// - Select codes 011-000 pick receive-side events
// - Standard: tx full on write, clear on load
// - Enhanced: tx full while no slot free
// - Standard: rx full on receive, clear on read
// - Enhanced: rx full while no slot free
// - Clock-off frees clock pin; master bit selects role
// - Data-out-off bit releases the data output pin
// - Word-size bit picks 16 or 8 bits
// - Master samples at end or middle
// - Idle clock level and output change edge
// - Slave uses select pin when enabled
// - Two prescalers divide the master clock
// - Framed mode puts sync on select pin
// - Sync direction and polarity bits
// - Sync with first bit or one before
// - Buffer-mode bit picks FIFO or single entry
// - Each FIFO holds eight words
// - Sample phase only set with master mode
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module spf_port
   import spf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        idle_mode,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   output logic             sdo_o,
   output logic             sdo_oe,
   input  wire logic        sdi_i,
   input  wire logic        ss_i,
   output logic             ss_o,
   output logic             ss_oe,
   output logic             buf_event
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_C   = (AW+1)'(1);
   localparam logic [AW:0] Q3_C    = (AW+1)'((DEPTH * 3) / 4);

   if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("DEPTH must be a power of two from 2 to 8");
   end

   // Register state
   logic [15:0]  con1_reg, con2_reg;
   logic         port_on_reg, idle_halt_reg, ovf_reg;
   spf_irq_condition_sel_e   irq_condition_sel_reg;
   logic [31:0]  prdata_reg;
   // Pin synchronisers: {sck, sdi, ss}
   logic [2:0]   meta_reg, sync_reg;
   logic         sck_d_reg;
   // Engine
   spf_state_e   st_reg;
   logic [5:0]   k_reg, rcnt_reg;
   logic [9:0]   div_cnt_reg;
   logic [15:0]  tx_sh_reg, rx_sh_reg;
   logic         act_reg, fs_reg, loaded_reg, event_reg;
   // FIFOs
   logic [15:0]  tx_mem [DEPTH];
   logic [15:0]  rx_mem [DEPTH];
   logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   logic [AW:0]  tx_cnt_reg, rx_cnt_reg;

   // Configuration decode
   logic master, wide, sample_phase, cke, clock_idle_level, select_pin_use, framed, fsd, fpol, fdly, fifo_on;
   assign master  = con1_reg[B_MASTER];
   assign wide    = con1_reg[B_WIDE];
   assign sample_phase     = con1_reg[B_SMP] & master;
   assign cke     = con1_reg[B_CKE] & ~framed;
   assign clock_idle_level     = con1_reg[B_CKP];
   assign select_pin_use    = con1_reg[B_SELECT_PIN_USE] & ~framed;
   assign framed  = con2_reg[B_FRAMED];
   assign fsd     = con2_reg[B_SYNC_DIR];
   assign fpol    = con2_reg[B_SYNC_POL];
   assign fdly    = con2_reg[B_SYNC_EDGE];
   assign fifo_on = con2_reg[B_FIFO_ON];

   logic          halt, busy;
   logic [AW:0]   cap;
   logic          tx_full, rx_full, rx_empty;
   logic [5:0]    n2, nb;
   assign halt     = ~port_on_reg | (idle_halt_reg & idle_mode);
   assign busy     = st_reg != ST_IDLE;
   assign cap      = fifo_on ? DEPTH_C : ONE_C;
   assign tx_full  = tx_cnt_reg == cap;
   assign rx_full  = rx_cnt_reg == cap;
   assign rx_empty = rx_cnt_reg == '0;
   assign nb       = wide ? BITS_WORD : BITS_BYTE;
   assign n2       = 6'(nb << 1);

   // APB access
   logic acc, wr_acc, rd_acc, mapped;
   assign acc     = psel & penable;
   assign wr_acc  = acc & pwrite;
   assign rd_acc  = acc & ~pwrite;
   assign mapped  = paddr == OFF_STAT || paddr == OFF_CON1 ||
                    paddr == OFF_CON2 || paddr == OFF_DATA;
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = prdata_reg;

   logic [2:0]  cnt3;
   logic [15:0] stat_val;
   assign cnt3 = master ? 3'(tx_cnt_reg) : 3'(rx_cnt_reg);
   always_comb begin
      stat_val = RESET_VAL;
      stat_val[B_PORT_ON] = port_on_reg;
      stat_val[B_IDLE_HALT] = idle_halt_reg;
      stat_val[B_CNT_LO +: 3] = cnt3;
      stat_val[B_SH_EMPTY] = ~busy;
      stat_val[B_OVF] = ovf_reg;
      stat_val[B_RX_EMPTY] = rx_empty;
      stat_val[B_IRQ_CONDITION_SEL_LO +: 3] = irq_condition_sel_reg;
      stat_val[B_TX_FULL] = tx_full;
      stat_val[B_RX_FULL] = rx_full;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFF_STAT: prdata_reg <= {16'h0, stat_val};
            OFF_CON1: prdata_reg <= {16'h0, con1_reg};
            OFF_CON2: prdata_reg <= {16'h0, con2_reg};
            OFF_DATA: prdata_reg <= {16'h0, rx_mem[rx_rp_reg]};
            default:  prdata_reg <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         con1_reg      <= RESET_VAL;
         con2_reg      <= RESET_VAL;
         port_on_reg   <= 1'b0;
         idle_halt_reg <= 1'b0;
         irq_condition_sel_reg     <= SEL_RX_EMPTIED;
      end else if (wr_acc) begin
         if (paddr == OFF_STAT) begin
            port_on_reg   <= pwdata[B_PORT_ON];
            idle_halt_reg <= pwdata[B_IDLE_HALT];
            irq_condition_sel_reg     <= spf_irq_condition_sel_e'(pwdata[B_IRQ_CONDITION_SEL_LO +: 3]);
         end
         if (paddr == OFF_CON1) begin
            con1_reg <= pwdata[15:0] & CON1_WMASK;
         end
         if (paddr == OFF_CON2) begin
            con2_reg <= pwdata[15:0] & CON2_WMASK;
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg  <= 3'h0;
         sync_reg  <= 3'h0;
         sck_d_reg <= 1'b0;
      end else begin
         meta_reg  <= {sck_i, sdi_i, ss_i};
         sync_reg  <= meta_reg;
         sck_d_reg <= sync_reg[2];
      end
   end

   logic sck_s, sdi_s, ss_s, fs_in, sel_ok;
   assign sck_s  = sync_reg[2];
   assign sdi_s  = sync_reg[1];
   assign ss_s   = sync_reg[0];
   assign fs_in  = fpol ? ss_s : ~ss_s;
   assign sel_ok = ~select_pin_use | ~ss_s;

   // Prescaler
   logic [6:0] pri;
   logic [3:0] sec;
   logic [9:0] div;
   logic       tick;
   always_comb begin
      unique case (con1_reg[B_PRI_LO +: 2])
         2'h3: pri = PRI_1;
         2'h2: pri = PRI_4;
         2'h1: pri = PRI_16;
         2'h0: pri = PRI_64;
      endcase
   end
   assign sec  = SEC_BASE - {1'b0, con1_reg[B_SEC_LO +: 3]};
   assign div  = 10'(pri) * 10'(sec);
   assign tick = div_cnt_reg == div - 10'h1;

   // Edge events for the shifter
   logic edge_s, lead, m_ev, ev, samp, shft, m_start, s_load, abort;
   logic s_go, s_arm, finish;
   assign edge_s  = sck_s ^ sck_d_reg;
   assign m_ev    = master & tick & (st_reg == ST_SHIFT) & ~halt;
   assign s_go    = (st_reg == ST_SHIFT) |
                    (st_reg == ST_IDLE & (framed ? lead & fs_in & fdly : sel_ok)) |
                    (st_reg == ST_ARM & lead);
   assign s_arm   = ~master & edge_s & ~halt & st_reg == ST_IDLE & framed &
                    lead & fs_in & ~fdly;
   assign abort   = ~master & select_pin_use & ss_s;
   assign ev      = master ? m_ev : edge_s & s_go & ~halt & ~abort;
   // Leading edge means idle-to-active
   assign lead    = master ? ~k_reg[0] : (sck_s ^ clock_idle_level);
   // Sample at the middle or end of the output time
   assign samp    = ev & (lead == (cke ^ sample_phase)) & (rcnt_reg < nb) &
                    ~(k_reg == 6'h0 & ~cke);
   assign shft    = ev & (lead != cke) & k_reg != 6'h0 & (k_reg < n2 - 6'h1);
   assign finish  = ev & (master ? k_reg == n2 : k_reg == n2 - 6'h1);
   assign m_start = master & ~halt & st_reg == ST_IDLE & tx_cnt_reg != '0 &
                    (~framed | ~fsd | fs_in);
   assign s_load  = ~master & ~halt & ~loaded_reg & tx_cnt_reg != '0 &
                    (st_reg == ST_IDLE | st_reg == ST_ARM);

   logic tx_push, tx_pop, rx_push, rx_pop, ovf_set;
   assign tx_push = wr_acc & paddr == OFF_DATA & ~tx_full;
   assign tx_pop  = m_start | s_load;
   assign rx_push = finish & ~rx_full;
   assign ovf_set = finish & rx_full;
   assign rx_pop  = rd_acc & paddr == OFF_DATA & ~rx_empty;

   // Engine state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg      <= ST_IDLE;
         k_reg       <= 6'h0;
         rcnt_reg    <= 6'h0;
         div_cnt_reg <= 10'h0;
         act_reg     <= 1'b0;
         fs_reg      <= 1'b0;
         loaded_reg  <= 1'b0;
      end else if (!port_on_reg || abort) begin
         st_reg      <= ST_IDLE;
         k_reg       <= 6'h0;
         rcnt_reg    <= 6'h0;
         act_reg     <= 1'b0;
         fs_reg      <= 1'b0;
         // A word loaded while deselected stays put until selected
         loaded_reg  <= (loaded_reg | s_load) & port_on_reg;
      end else begin
         div_cnt_reg <= (tick || st_reg == ST_IDLE || halt) ? 10'h0 : div_cnt_reg + 10'h1;
         if (halt) begin
            div_cnt_reg <= div_cnt_reg;
         end
         if (s_load) begin
            loaded_reg <= 1'b1;
         end
         if (s_arm) begin
            st_reg <= ST_ARM;
         end
         if (m_start) begin
            st_reg <= (framed && !fsd && !fdly) ? ST_PRE : ST_SHIFT;
            fs_reg <= framed & ~fsd;
            k_reg  <= 6'h0;
         end
         if (master && tick && !halt && st_reg == ST_PRE) begin
            act_reg <= ~act_reg;
            k_reg   <= k_reg == 6'h1 ? 6'h0 : k_reg + 6'h1;
            if (k_reg == 6'h1) begin
               st_reg <= ST_SHIFT;
               fs_reg <= 1'b0;
            end
         end
         if (ev && !finish) begin
            st_reg <= ST_SHIFT;
            k_reg  <= k_reg + 6'h1;
            if (master) begin
               act_reg <= ~act_reg;
            end
            if (master && k_reg == 6'h1) begin
               fs_reg <= 1'b0;
            end
         end
         if (samp) begin
            rcnt_reg <= rcnt_reg + 6'h1;
         end
         if (finish) begin
            st_reg     <= ST_IDLE;
            k_reg      <= 6'h0;
            rcnt_reg   <= 6'h0;
            loaded_reg <= 1'b0;
         end
      end
   end

   // Shift registers; byte data is held in the top half for sending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sh_reg <= 16'h0;
         rx_sh_reg <= 16'h0;
      end else begin
         if (tx_pop) begin
            tx_sh_reg <= wide ? tx_mem[tx_rp_reg] : {tx_mem[tx_rp_reg][7:0], 8'h0};
         end else if (shft) begin
            tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
         end
         if (samp) begin
            rx_sh_reg <= {rx_sh_reg[14:0], sdi_s};
         end
      end
   end

   // Transmit FIFO
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wp_reg  <= '0;
         tx_rp_reg  <= '0;
         tx_cnt_reg <= '0;
      end else if (!port_on_reg) begin
         tx_wp_reg  <= '0;
         tx_rp_reg  <= '0;
         tx_cnt_reg <= '0;
      end else begin
         if (tx_push) begin
            tx_wp_reg <= tx_wp_reg + 1'b1;
         end
         if (tx_pop) begin
            tx_rp_reg <= tx_rp_reg + 1'b1;
         end
         tx_cnt_reg <= tx_cnt_reg + (tx_push ? ONE_C : '0) - (tx_pop ? ONE_C : '0);
      end
   end

   // The closing edge may carry the last sample, so store it with the word
   logic [15:0] rx_word;
   assign rx_word = samp ? {rx_sh_reg[14:0], sdi_s} : rx_sh_reg;

   always_ff @(posedge pclk) begin
      if (tx_push) begin
         tx_mem[tx_wp_reg] <= pwdata[15:0];
      end
      if (rx_push) begin
         rx_mem[rx_wp_reg] <= wide ? rx_word : {8'h0, rx_word[7:0]};
      end
   end

   // Receive FIFO
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp_reg  <= '0;
         rx_rp_reg  <= '0;
         rx_cnt_reg <= '0;
      end else if (!port_on_reg) begin
         rx_wp_reg  <= '0;
         rx_rp_reg  <= '0;
         rx_cnt_reg <= '0;
      end else begin
         if (rx_push) begin
            rx_wp_reg <= rx_wp_reg + 1'b1;
         end
         if (rx_pop) begin
            rx_rp_reg <= rx_rp_reg + 1'b1;
         end
         rx_cnt_reg <= rx_cnt_reg + (rx_push ? ONE_C : '0) - (rx_pop ? ONE_C : '0);
      end
   end

   // Overflow: a new arrival wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_reg <= 1'b0;
      end else if (ovf_set) begin
         ovf_reg <= 1'b1;
      end else if (wr_acc && paddr == OFF_STAT && !pwdata[B_OVF]) begin
         ovf_reg <= 1'b0;
      end
   end

   // Buffer event selection
   logic ev_sel;
   always_comb begin
      unique case (irq_condition_sel_reg)
         SEL_TX_FULL:    ev_sel = tx_full;
         SEL_TX_DRAINED: ev_sel = tx_pop & tx_cnt_reg == ONE_C;
         SEL_TX_DONE:    ev_sel = finish;
         SEL_TX_SLOT:    ev_sel = tx_pop & tx_cnt_reg == cap;
         SEL_RX_FULL:    ev_sel = rx_full;
         SEL_RX_3Q:      ev_sel = rx_cnt_reg >= Q3_C;
         SEL_RX_AVAIL:   ev_sel = ~rx_empty;
         SEL_RX_EMPTIED: ev_sel = rx_pop & rx_cnt_reg == ONE_C;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_reg <= 1'b0;
      end else begin
         event_reg <= fifo_on ? ev_sel : rx_full;
      end
   end
   assign buf_event = event_reg;

   // Pin drive
   assign sck_o  = clock_idle_level ^ act_reg;
   assign sck_oe = port_on_reg & master & ~con1_reg[B_CLK_OFF];
   assign sdo_o  = tx_sh_reg[15];
   assign sdo_oe = port_on_reg & ~con1_reg[B_DOUT_OFF] &
                   (master | ~select_pin_use | ~ss_s);
   assign ss_o   = fpol ? fs_reg : ~fs_reg;
   assign ss_oe  = port_on_reg & framed & ~fsd & master;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_full_arrival;
      finish && rx_full;
   endsequence
   sequence s_std_write;
      tx_push && !fifo_on && !tx_pop && port_on_reg;
   endsequence

   port_off_pins_a: assert property (!port_on_reg |-> !sck_oe && !sdo_oe && !ss_oe)
      else $error("pins driven while port off");
   halt_hold_a: assert property (halt && st_reg == ST_IDLE |=> st_reg == ST_IDLE)
      else $error("engine started while halted");
   tx_full_set_a: assert property (s_std_write |=> tx_full)
      else $error("tx full not set by write");
   ovf_drop_a: assert property (s_full_arrival |=> ovf_reg && $stable(rx_wp_reg))
      else $error("overflow not flagged or data kept");
   rx_read_a: assert property (rx_pop && !fifo_on && !rx_push |=> !rx_full)
      else $error("rx full not cleared by read");
   clk_off_a: assert property (con1_reg[B_CLK_OFF] |-> !sck_oe)
      else $error("clock pin driven while disabled");
   dout_off_a: assert property (con1_reg[B_DOUT_OFF] |-> !sdo_oe)
      else $error("data pin driven while disabled");
   bit_count_a: assert property (finish |-> rcnt_reg + 6'(samp) == nb)
      else $error("wrong number of bits sampled");
   div_range_a: assert property (busy && master && !halt |-> div_cnt_reg < div)
      else $error("prescaler count beyond ratio");
   pre_sync_a: assert property (st_reg == ST_PRE |-> fs_reg ##0 !sck_oe || ss_oe)
      else $error("sync pulse missing before first bit");
endmodule // spf_port

/* spf_far_end.sv */
// Far-end serial device model: shifts MSB first, clock idle low.
// Assumes data changes on the falling clock edge and is sampled on the rising one.
`timescale 1ns/1ns
module spf_far_end (
   input  wire logic       sck,
   input  wire logic       sdo,
   input  wire logic [4:0] nbits,
   output logic            sdi,
   output logic            sck_drv
);
   logic [15:0] txq[$];
   logic [15:0] rxq[$];
   logic [15:0] sh_out;
   logic [15:0] sh_in;
   int          cnt;

   initial begin
      sdi = 1'b0;
      sck_drv = 1'b0;
      cnt = 0;
      sh_out = 16'h0000;
      sh_in = 16'h0000;
   end

   // Presents the next queued word; an empty queue gives zero
   task automatic next_word();
      sh_out = (txq.size() > 0) ? txq.pop_front() : 16'h0000;
      sdi = sh_out[nbits-1];
   endtask

   // One frame of clock when this end is master; the clock stands low between frames
   task automatic frame();
      #13;
      repeat (nbits) begin
         #40 sck_drv = 1'b1;
         #40 sck_drv = 1'b0;
      end
   endtask

   always @(posedge sck) begin
      sh_in = {sh_in[14:0], sdo};
      cnt = cnt + 1;
      if (cnt == nbits) begin
         rxq.push_back(sh_in & ((16'h0001 << nbits) - 16'h0001));
         cnt = 0;
      end
   end

   // Output moves on the opposite edge, so a mid-bit sample sees it settled
   always @(negedge sck) begin
      if (cnt == 0)
         next_word();
      else
         sdi = sh_out[nbits-1-cnt];
   end
endmodule // spf_far_end

/* spf_port_tb.sv */
// Bench for spf_port: registers over APB, serial traffic against a far-end model.
// Assumes zero-wait APB answers and a far end in mode idle-low, change-on-fall.
`timescale 1ns/1ns
module spf_port_tb
   import spf_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, idle_mode, err, ss_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, r;
   logic [4:0]  nbits;
   logic [15:0] mask;
   logic [15:0] exp_far[$], exp_dut[$];
   int          n_mismatch, check_count, cycles, i;
   wire  [31:0] prdata;
   wire         pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe, sdi_i;
   wire         ss_o, ss_oe, buf_event, sck_drv;
   wire         sck_line = sck_oe ? sck_o : sck_drv;
   // A released data pin reads back inverted, so a stray frame shows up
   wire         sdo_line = sdo_oe ? sdo_o : ~sdo_o;

   spf_port dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .idle_mode(idle_mode), .sck_i(sck_line), .sck_o(sck_o),
      .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sdi_i(sdi_i), .ss_i(ss_pin),
      .ss_o(ss_o), .ss_oe(ss_oe), .buf_event(buf_event)
   );
   spf_far_end far (
      .sck(sck_line), .sdo(sdo_line), .nbits(nbits), .sdi(sdi_i), .sck_drv(sck_drv)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report();
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cfg(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] st);
      apb(OFF_STAT, 1'b1, 32'h0);
      apb(OFF_CON1, 1'b1, {16'h0, c1});
      apb(OFF_CON2, 1'b1, {16'h0, c2});
      apb(OFF_STAT, 1'b1, {16'h0, st});
      nbits = c1[B_WIDE] ? 5'h10 : 5'h08;
      mask = c1[B_WIDE] ? 16'hffff : 16'h00ff;
      // Let the last register write settle before pins are looked at
      @(negedge pclk);
   endtask

   task automatic burst(input int n);
      logic [15:0] v;
      repeat (n) begin
         v = 16'($urandom) & mask;
         far.txq.push_back(v);
         exp_dut.push_back(v);
      end
      far.next_word();
      repeat (n) begin
         v = 16'($urandom) & mask;
         apb(OFF_DATA, 1'b1, {16'h0, v});
         exp_far.push_back(v);
      end
   endtask

   task automatic settle(input int nf);
      while (far.rxq.size() < nf) begin
         @(posedge pclk);
      end
      repeat (20) @(posedge pclk);
   endtask

   task automatic drain(input int nd);
      while (far.rxq.size() > 0) chk(far.rxq.pop_front(), exp_far.pop_front());
      repeat (nd) begin
         apb(OFF_DATA, 1'b0, 32'h0);
         chk(r, {16'h0, exp_dut.pop_front()});
      end
      apb(OFF_STAT, 1'b0, 32'h0);
      chk(r[B_RX_FULL], 1'b0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      idle_mode = 1'b0;
      ss_pin = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      nbits = 5'h08;
      mask = 16'h00ff;
      i = $urandom(32'h6678268e);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, write masks, unmapped access, every select code
      for (i = 0; i < 3; i++) begin
         apb(12'(i * 4), 1'b0, 32'h0);
         chk(r, (i == 0) ? 32'((1 << B_SH_EMPTY) | (1 << B_RX_EMPTY))
                         : {16'h0, RESET_VAL});
      end
      apb(OFF_CON1, 1'b1, 32'hffff);
      apb(OFF_CON1, 1'b0, 32'h0);
      chk(r, {16'h0, CON1_WMASK});
      apb(OFF_CON2, 1'b1, 32'hffff);
      apb(OFF_CON2, 1'b0, 32'h0);
      chk(r, {16'h0, CON2_WMASK});
      apb(12'h010, 1'b0, 32'h0);
      chk({r[30:0], err}, 32'h1);
      for (i = 0; i < 8; i++) begin
         apb(OFF_STAT, 1'b1, 32'(i << 2));
         apb(OFF_STAT, 1'b0, 32'h0);
         chk(r & 32'h1c, 32'(i << 2));
      end
      // Master, FIFO, bytes, event on data available
      cfg(16'h013e, 16'h0001, 16'h8004);
      chk({sck_oe, sdo_oe}, 32'h3);
      chk({ss_oe, ss_o}, 32'h1);
      burst(5);
      settle(5);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk({r[B_SH_EMPTY], r[B_RX_EMPTY], buf_event}, 32'h5);
      drain(5);
      chk({r[B_RX_EMPTY], buf_event}, 32'h2);
      // Halted in idle: fill the FIFO, one write refused, then release
      @(posedge pclk) idle_mode <= 1'b1;
      cfg(16'h013e, 16'h0001, 16'ha000);
      burst(8);
      apb(OFF_DATA, 1'b1, 32'h00a5);
      repeat (100) @(posedge pclk);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk({r[B_TX_FULL], r[10:8]}, 32'h8);
      chk(far.rxq.size(), 32'h0);
      @(posedge pclk) idle_mode <= 1'b0;
      settle(8);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk({r[B_TX_FULL], r[B_RX_FULL]}, 32'h1);
      drain(8);
      // Standard buffer: second word while first unread overflows
      cfg(16'h013e, 16'h0000, 16'h8000);
      burst(1);
      settle(1);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk({r[B_TX_FULL], r[B_RX_FULL], buf_event}, 32'h3);
      burst(1);
      settle(2);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk(r[B_OVF], 1'b1);
      void'(exp_dut.pop_back());
      drain(1);
      apb(OFF_STAT, 1'b1, 32'h8000);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk(r[B_OVF], 1'b0);
      // Slave, 16-bit words, clock from the far end
      cfg(16'h0580, 16'h0001, 16'h8000);
      chk({sck_oe, sdo_oe}, 32'h0);
      @(posedge pclk) ss_pin <= 1'b0;
      repeat (3) @(negedge pclk);
      chk({sck_oe, sdo_oe}, 32'h1);
      burst(2);
      repeat (2) far.frame();
      settle(2);
      apb(OFF_STAT, 1'b0, 32'h0);
      chk(r[10:8], 32'h2);
      drain(2);
      final_report();
   end
endmodule // spf_port_tb
